// file: src/evmf_axil_slave.sv
/*
  axi4-lite slave front end: takes one write and one read at a time and hands
  them to the register file as a one-cycle write pulse and a read lookup.
  assumes the register file answers the read lookup combinationally.
*/
`timescale 1ns/100ps
module evmf_axil_slave (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // axi4-lite
  input wire logic [evmf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [evmf_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register file side
  output evmf_pkg::evmf_wreq_type wreq,
  output logic wr_pulse,
  input wire logic wr_ok,
  output logic [7:0] rd_idx,
  input wire logic [31:0] rd_word,
  input wire logic rd_ok
);
  import evmf_pkg::*;

  logic aw_held_r;
  logic w_held_r;
  logic bvalid_r;
  logic rvalid_r;
  logic [7:0] aw_idx_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic fire;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_pulse = fire;
  assign wreq = '{idx: aw_idx_r, data: w_data_r, strb: w_strb_r};
  assign rd_idx = s_axi_araddr[IDX_LSB +: IDX_W];
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      aw_idx_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[IDX_LSB +: IDX_W];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_ok ? rd_word : 32'h0000_0000;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule : evmf_axil_slave

// file: src/evmf_pkg.sv
/*
  constants, field layout and carrier types for the encoder mean-speed filter.
  assumes one 25 MHz system clock and a 32-bit axi4-lite register bus.
*/
package evmf_pkg;
  localparam int AXI_AW = 12;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_ZERO_DELAY = 8'h62;
  localparam logic [7:0] IDX_AVG_CFG = 8'h63;
  localparam logic [7:0] IDX_SPEED = 8'h65;
  localparam logic [7:0] IDX_POLL = 8'h80;
  localparam logic [7:0] IDX_MODE = 8'h81;
  localparam logic [7:0] IDX_RES = 8'h82;
  localparam logic [7:0] IDX_STATUS = 8'h83;
  localparam logic [7:0] IDX_LIMIT = 8'h84;
  // averaging config field layout
  localparam int GAP_LSB = 0;
  localparam int GAP_W = 8;
  localparam int FILT_LSB = 8;
  localparam int FILT_W = 4;
  localparam int INT_LSB = 16;
  localparam int INT_W = 16;
  localparam int MODE_ABS_BIT = 0;
  localparam int STAT_STEP_BIT = 0;
  // reset values
  localparam logic [31:0] AVG_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_DELAY_RST = 32'h00ff_ffff;
  localparam logic [31:0] POLL_RST = 32'h0000_0000;
  localparam logic [31:0] RES_RST = 32'h0000_0000;
  localparam logic [31:0] SPEED_RST = 32'h0000_0000;
  // timing and limit figures
  localparam logic [15:0] MIN_INTERVAL = 16'h0100;
  localparam int RES_DIV8_SH = 3;
  localparam int MULT_SH = 11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } evmf_wreq_type;

  typedef struct packed {
    logic valid;
    logic [31:0] pos;
  } evmf_enc_type;
endpackage : evmf_pkg

// file: src/evmf_top.sv
/*
  encoder mean-speed filter: forms raw encoder speed, averages it, checks
  absolute readings for plausibility and paces the closed-loop cycle.
  assumes position samples arrive already decoded from the encoder receiver,
  synchronous to mclk, and that software reaches the registers over axi4-lite.
*/
// The implementer's own choice: register access over AXI4-Lite.
// Notes on behaviour
// - wait the programmed 8-bit gap in clocks between samples fed to the mean
// - with an absolute encoder the sample gap is the serial poll period
// - absolute step limit is multiplier/256 times one eighth of resolution
// - multiplier zero means step limit is one eighth of resolution
// - the 4-bit exponent field sets the averaging filter exponent
// - incremental speed updates once per 16-bit programmed interval in clocks
// - intervals below 256 clocks are raised to 256; the absolute-mode control cycle from the upper field is used unraised
// - absolute mode runs the control cycle counted in clocks, upper field, until a poll period is set
// - control cycle set automatically to the fastest the encoder allows
// - incremental mode: mean speed forced to zero after programmed idle time without position change
`timescale 1ns/100ps
module evmf_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // axi4-lite register bus
  input wire logic [evmf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [evmf_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decoded encoder position
  input wire evmf_pkg::evmf_enc_type measured_shaft_speed,
  // results
  output logic [31:0] mean_shaft_speed,
  output logic loop_tick,
  output logic step_rejected
);
  import evmf_pkg::*;

  evmf_wreq_type wreq;
  logic wr_pulse;
  logic wr_ok;
  logic [7:0] rd_idx;
  logic [31:0] rd_word;
  logic rd_ok;

  evmf_axil_slave u_bus (
    .mclk(mclk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wreq(wreq),
    .wr_pulse(wr_pulse),
    .wr_ok(wr_ok),
    .rd_idx(rd_idx),
    .rd_word(rd_word),
    .rd_ok(rd_ok)
  );

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // software registers
  logic [31:0] avg_cfg_r;
  logic [31:0] zero_delay_r;
  logic [31:0] poll_r;
  logic [31:0] res_r;
  logic mode_abs_r;
  logic step_flag_r;

  // datapath state
  logic [31:0] pos_r;
  logic have_pos_r;
  logic [31:0] int_base_r;
  logic [31:0] raw_speed_r;
  logic [31:0] mean_r;
  logic [31:0] gap_cnt_r;
  logic [15:0] int_cnt_r;
  logic [31:0] loop_cnt_r;
  logic [31:0] idle_cnt_r;
  logic idle_r;
  logic loop_tick_r;
  logic step_rej_r;

  logic wr_cfg;
  logic wr_zero;
  logic wr_poll;
  logic wr_res;
  logic wr_mode;
  logic wr_stat;

  assign wr_cfg = wr_pulse && (wreq.idx == IDX_AVG_CFG);
  assign wr_zero = wr_pulse && (wreq.idx == IDX_ZERO_DELAY);
  assign wr_poll = wr_pulse && (wreq.idx == IDX_POLL);
  assign wr_res = wr_pulse && (wreq.idx == IDX_RES);
  assign wr_mode = wr_pulse && (wreq.idx == IDX_MODE);
  assign wr_stat = wr_pulse && (wreq.idx == IDX_STATUS);
  assign wr_ok = wr_cfg || wr_zero || wr_poll || wr_res || wr_mode || wr_stat;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avg_cfg_r <= AVG_CFG_RST;
    end else if (wr_cfg) begin
      avg_cfg_r <= merge(avg_cfg_r, wreq.data, wreq.strb);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      zero_delay_r <= ZERO_DELAY_RST;
      poll_r <= POLL_RST;
      res_r <= RES_RST;
      mode_abs_r <= 1'b0;
    end else begin
      if (wr_zero) begin
        zero_delay_r <= merge(zero_delay_r, wreq.data, wreq.strb);
      end
      if (wr_poll) begin
        poll_r <= merge(poll_r, wreq.data, wreq.strb);
      end
      if (wr_res) begin
        res_r <= merge(res_r, wreq.data, wreq.strb);
      end
      if (wr_mode && wreq.strb[0]) begin
        mode_abs_r <= wreq.data[MODE_ABS_BIT];
      end
    end
  end

  // effective settings
  logic [7:0] gap_field;
  logic [3:0] filt_exp;
  logic [15:0] int_field;
  logic [15:0] int_eff;
  logic [31:0] gap_eff;
  logic [31:0] loop_eff;
  logic [39:0] mult_prod;
  logic [31:0] step_limit;

  assign gap_field = avg_cfg_r[GAP_LSB +: GAP_W];
  assign filt_exp = avg_cfg_r[FILT_LSB +: FILT_W];
  assign int_field = avg_cfg_r[INT_LSB +: INT_W];
  assign int_eff = (int_field < MIN_INTERVAL) ? MIN_INTERVAL : int_field;
  assign gap_eff = mode_abs_r ? poll_r : {24'h00_0000, gap_field};
  // fastest cycle is one serial poll; the field serves until a poll period is set
  assign loop_eff = (poll_r != 32'h0000_0000) ? poll_r : {16'h0000, int_field};
  assign mult_prod = res_r * gap_field;
  assign step_limit = (gap_field == 8'h00) ? (res_r >> RES_DIV8_SH) :
    {3'b000, mult_prod[MULT_SH +: 29]};

  // sample gap timer feeding the mean
  logic gap_tick;
  assign gap_tick = (gap_cnt_r + 32'h0000_0001) >= gap_eff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gap_cnt_r <= 32'h0000_0000;
    end else if (gap_tick) begin
      gap_cnt_r <= 32'h0000_0000;
    end else begin
      gap_cnt_r <= gap_cnt_r + 32'h0000_0001;
    end
  end

  // incremental speed interval timer
  logic int_tick;
  assign int_tick = !mode_abs_r && ((int_cnt_r + 16'h0001) >= int_eff);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_cnt_r <= 16'h0000;
    end else if (mode_abs_r || int_tick) begin
      int_cnt_r <= 16'h0000;
    end else begin
      int_cnt_r <= int_cnt_r + 16'h0001;
    end
  end

  // closed-loop control cycle timer, absolute mode only
  logic loop_hit;
  assign loop_hit = (loop_cnt_r + 32'h0000_0001) >= loop_eff;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      loop_cnt_r <= 32'h0000_0000;
      loop_tick_r <= 1'b0;
    end else if (!mode_abs_r) begin
      loop_cnt_r <= 32'h0000_0000;
      loop_tick_r <= 1'b0;
    end else if (loop_hit) begin
      loop_cnt_r <= 32'h0000_0000;
      loop_tick_r <= 1'b1;
    end else begin
      loop_cnt_r <= loop_cnt_r + 32'h0000_0001;
      loop_tick_r <= 1'b0;
    end
  end

  // absolute reading plausibility
  logic [31:0] step_delta;
  logic [31:0] step_mag;
  logic abs_bad;
  logic abs_take;
  assign step_delta = measured_shaft_speed.pos - pos_r;
  assign step_mag = step_delta[31] ? (32'h0000_0000 - step_delta) : step_delta;
  assign abs_bad = mode_abs_r && measured_shaft_speed.valid && have_pos_r && (step_mag > step_limit);
  assign abs_take = mode_abs_r && measured_shaft_speed.valid && !abs_bad;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pos_r <= 32'h0000_0000;
      have_pos_r <= 1'b0;
    end else if (measured_shaft_speed.valid && !abs_bad) begin
      pos_r <= measured_shaft_speed.pos;
      have_pos_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      step_rej_r <= 1'b0;
    end else begin
      step_rej_r <= abs_bad;
    end
  end

  // sticky flag, a new rejection wins over a write-one clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      step_flag_r <= 1'b0;
    end else if (abs_bad) begin
      step_flag_r <= 1'b1;
    end else if (wr_stat && wreq.strb[0] && wreq.data[STAT_STEP_BIT]) begin
      step_flag_r <= 1'b0;
    end
  end

  // idle timer since last incremental position change
  logic pos_moved;
  assign pos_moved = measured_shaft_speed.valid && (measured_shaft_speed.pos != pos_r);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idle_cnt_r <= 32'h0000_0000;
      idle_r <= 1'b0;
    end else if (mode_abs_r || pos_moved) begin
      idle_cnt_r <= 32'h0000_0000;
      idle_r <= 1'b0;
    end else if (idle_cnt_r >= zero_delay_r) begin
      idle_r <= 1'b1;
    end else begin
      idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
    end
  end

  // raw speed: per interval when incremental, per reading when absolute
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      int_base_r <= 32'h0000_0000;
    end else if (int_tick) begin
      int_base_r <= measured_shaft_speed.valid ? measured_shaft_speed.pos : pos_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      raw_speed_r <= SPEED_RST;
    end else if (abs_take) begin
      raw_speed_r <= have_pos_r ? step_delta : 32'h0000_0000;
    end else if (int_tick) begin
      raw_speed_r <= (measured_shaft_speed.valid ? measured_shaft_speed.pos : pos_r) - int_base_r;
    end else if (idle_r) begin
      raw_speed_r <= 32'h0000_0000;
    end
  end

  // running average
  logic [32:0] diff;
  logic [32:0] step;
  logic [32:0] mean_sum;
  assign diff = {raw_speed_r[31], raw_speed_r} - {mean_r[31], mean_r};
  assign step = $signed(diff) >>> filt_exp;
  assign mean_sum = {mean_r[31], mean_r} + step;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mean_r <= SPEED_RST;
    end else if (idle_r) begin
      mean_r <= 32'h0000_0000;
    end else if (gap_tick) begin
      mean_r <= mean_sum[31:0];
    end
  end

  // register readback
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (rd_idx)
      IDX_AVG_CFG: rd_word = 32'h0000_0000;
      IDX_ZERO_DELAY: rd_word = 32'h0000_0000;
      IDX_SPEED: rd_word = mean_r;
      IDX_POLL: rd_word = poll_r;
      IDX_MODE: rd_word = {31'h0000_0000, mode_abs_r};
      IDX_RES: rd_word = res_r;
      IDX_STATUS: rd_word = {31'h0000_0000, step_flag_r};
      IDX_LIMIT: rd_word = step_limit;
      default: rd_ok = 1'b0;
    endcase
  end

  assign mean_shaft_speed = mean_r;
  assign loop_tick = loop_tick_r;
  assign step_rejected = step_rej_r;
endmodule : evmf_top

// file: verification/encoder_velocity_mean_filter_bench.sv
/*
  testbench for the encoder mean-speed filter: axi4-lite tasks and scenarios.
  assumes the encoder partner model and the bound checker.
*/
`timescale 1ns/100ps
module encoder_velocity_mean_filter_bench;
  import evmf_pkg::*;
  logic mclk, rst_n;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, mean_shaft_speed;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic loop_tick, step_rejected;
  logic [15:0] period;
  logic [31:0] step;
  evmf_enc_type measured_shaft_speed;
  int num_errors, checks_done, t, r;
  evmf_top u_evmf_top (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .measured_shaft_speed, .mean_shaft_speed,
    .loop_tick, .step_rejected);
  evmf_encoder_model u_evmf_encoder_model (.mclk, .rst_n, .period, .step, .measured_shaft_speed);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic tick(inout int n);
    @(negedge mclk);
    n++;
    if (n > 200) begin
      num_errors++;
      $display("ERROR %0t bus answer timeout", $time);
      complete_run();
    end
  endtask : tick
  task automatic ck_wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    logic ap, wp, ta, tw;
    n = 0;
    ap = 1'b1;
    wp = 1'b1;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (ap || wp) begin
      tick(n);
      ta = ap && s_axi_awready;
      tw = wp && s_axi_wready;
      @(posedge mclk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        ap = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        wp = 1'b0;
      end
    end
    do tick(n); while (!s_axi_bvalid);
    check_val({30'h0, s_axi_bresp}, {30'h0, rsp});
    @(posedge mclk);
  endtask : ck_wr
  task automatic ck_rd(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] rsp);
    int n;
    n = 0;
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do tick(n); while (!s_axi_arready);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    do tick(n); while (!s_axi_rvalid);
    check_val(s_axi_rdata, d);
    check_val({30'h0, s_axi_rresp}, {30'h0, rsp});
    @(posedge mclk);
  endtask : ck_rd
  task automatic count(input int n, output int ticks, output int rejects);
    ticks = 0;
    rejects = 0;
    repeat (n) begin
      @(negedge mclk);
      ticks += int'(loop_tick === 1'b1);
      rejects += int'(step_rejected === 1'b1);
    end
    @(posedge mclk);
  endtask : count
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    period = 16'h0000;
    step = 32'h0000_0000;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    ck_rd(IDX_SPEED, SPEED_RST, RESP_OKAY);
    ck_rd(IDX_ZERO_DELAY, 32'h0000_0000, RESP_OKAY);
    ck_rd(8'h10, 32'h0000_0000, RESP_SLVERR);
    ck_wr(8'h10, 32'h0000_0001, RESP_SLVERR);
    // incremental: one count every 4 cycles
    period <= 16'h0004;
    step <= 32'h0000_0001;
    ck_wr(IDX_AVG_CFG, 32'h0064_0028, RESP_OKAY);
    repeat (1000) @(posedge mclk);
    ck_rd(IDX_SPEED, 32'h0000_0040, RESP_OKAY);
    ck_wr(IDX_AVG_CFG, 32'h0200_0428, RESP_OKAY);
    repeat (3500) @(posedge mclk);
    ck_rd(IDX_SPEED, 32'h0000_0071, RESP_OKAY);
    ck_wr(IDX_ZERO_DELAY, 32'h0000_03e8, RESP_OKAY);
    period <= 16'h0000;
    repeat (1500) @(posedge mclk);
    ck_rd(IDX_SPEED, 32'h0000_0000, RESP_OKAY);
    // absolute: resolution 4096, poll every 50 cycles
    ck_wr(IDX_RES, 32'h0000_1000, RESP_OKAY);
    ck_wr(IDX_POLL, 32'h0000_0032, RESP_OKAY);
    ck_rd(IDX_POLL, 32'h0000_0032, RESP_OKAY);
    ck_wr(IDX_MODE, 32'h0000_0001, RESP_OKAY);
    ck_wr(IDX_AVG_CFG, 32'h0000_0000, RESP_OKAY);
    ck_rd(IDX_LIMIT, 32'h0000_0200, RESP_OKAY);
    ck_wr(IDX_AVG_CFG, 32'h0000_0080, RESP_OKAY);
    ck_rd(IDX_LIMIT, 32'h0000_0100, RESP_OKAY);
    period <= 16'h0032;
    step <= 32'h0000_00c8;
    repeat (300) @(posedge mclk);
    count(500, t, r);
    check_val(t, 32'h0000_000a);
    check_val(r, 32'h0000_0000);
    @(negedge mclk);
    check_val(mean_shaft_speed, 32'h0000_00c8);
    @(posedge mclk);
    ck_rd(IDX_SPEED, 32'h0000_00c8, RESP_OKAY);
    step <= 32'h0000_012c;
    repeat (100) @(posedge mclk);
    count(500, t, r);
    check_val(r, 32'h0000_000a);
    period <= 16'h0000;
    repeat (10) @(posedge mclk);
    ck_rd(IDX_STATUS, 32'h0000_0001, RESP_OKAY);
    ck_wr(IDX_STATUS, 32'h0000_0001, RESP_OKAY);
    ck_rd(IDX_STATUS, 32'h0000_0000, RESP_OKAY);
    complete_run();
  end
endmodule : encoder_velocity_mean_filter_bench

// file: verification/evmf_encoder_model.sv
/*
  encoder partner: emits a decoded position every period cycles, moved by step.
  assumes period and step come from the bench; period zero keeps it idle.
*/
`timescale 1ns/100ps
module evmf_encoder_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pacing
  input wire logic [15:0] period,
  input wire logic [31:0] step,
  // decoded position
  output evmf_pkg::evmf_enc_type measured_shaft_speed
);
  import evmf_pkg::*;
  logic [15:0] cnt_r;
  logic [31:0] pos_r;
  logic valid_r;
  always_ff @(posedge mclk) begin
    if (!rst_n || period == 16'h0000) begin
      cnt_r <= 16'h0000;
      valid_r <= 1'b0;
    end else if (cnt_r >= period - 16'h0001) begin
      cnt_r <= 16'h0000;
      pos_r <= pos_r + step;
      valid_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      valid_r <= 1'b0;
    end
    if (!rst_n) begin
      pos_r <= 32'h0000_0000;
    end
  end
  // position is not held outside the valid pulse
  assign measured_shaft_speed.valid = valid_r;
  assign measured_shaft_speed.pos = valid_r ? pos_r : ~pos_r;
endmodule : evmf_encoder_model

// file: verification/evmf_top_assertions.sv
/*
  checker for the encoder mean-speed filter: bus answers, readback, reset.
  assumes it is bound to evmf_top and sees only its ports.
*/
`timescale 1ns/100ps
module evmf_top_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register bus
  input wire logic [evmf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [evmf_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // results
  input wire logic [31:0] mean_shaft_speed,
  input wire logic loop_tick,
  input wire logic step_rejected
);
  import evmf_pkg::*;
  logic [7:0] aw_idx_r;
  function automatic logic mapped(input logic [7:0] idx);
    return idx inside {IDX_ZERO_DELAY, IDX_AVG_CFG, IDX_SPEED, [IDX_POLL:IDX_LIMIT]};
  endfunction : mapped
  always_ff @(posedge mclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_idx_r <= s_axi_awaddr[9:2];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
    mean_shaft_speed == 32'h0000_0000 && !loop_tick && !step_rejected)
    else $error("outputs not cleared by reset");
  a_write_answer: assert property (s_write_taken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_busy_refused: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    and (s_axi_rvalid |-> !s_axi_arready))
    else $error("request taken while answer pending");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  a_write_unmapped: assert property (s_axi_bvalid && !mapped(aw_idx_r) |->
    s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_read_unmapped: assert property (s_read_taken ##0 !mapped(s_axi_araddr[9:2]) |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_speed_readback: assert property (s_read_taken ##0 s_axi_araddr[9:2] == IDX_SPEED |=>
    s_axi_rdata == $past(mean_shaft_speed))
    else $error("speed register differs from port");
endmodule : evmf_top_assertions

bind evmf_top evmf_top_assertions u_evmf_top_assertions (.mclk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .mean_shaft_speed, .loop_tick, .step_rejected);
